// ### rss_seq.v
// reset start-up sequencer: delays, clock release, fail monitor arming and cause flags
`timescale 1ns/10ps
`include "rss_map.vh"

// Notes on behaviour
// - oscillator start-up runs independent of reset delays
// - core fetch held until clock released
// - armed monitor falls back to fast RC
// - crystal/PLL adds 100 us settle delay
// - power-on delay precedes operation except after brown-out
// - unready clock at monitor start traps
// - power-up delay precedes master reset release
// - external clock with PLL skips start-up timer
// - external/RC clock without PLL: no settle delay
// - control register reset on power-on only, kept over brown-out
// - osc control reset from configured source and PLL enable, same for every reset type
// - only word loads validate working registers
// - power-on delay 10 us before release
// - power-up delay select 0/4/16/64 ms
// - start-up timer counts 1024 oscillator periods
// - bad pointer use sets cause bit 14
module rss_seq #(
	parameter [31:0] PUD_4_CYC  = `RSS_PUD_4_CYC,
	parameter [31:0] PUD_16_CYC = `RSS_PUD_16_CYC,
	parameter [31:0] PUD_64_CYC = `RSS_PUD_64_CYC,
	parameter        NREG       = 15
) (
	// reference clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// reset events
	input  wire        por_pulse,
	input  wire        bor_pulse,
	input  wire        trap_conflict,
	// oscillator side
	input  wire        osc_tick,
	input  wire        pll_lock,
	input  wire        clk_alive,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// core side
	output reg         master_reset_q,
	output reg         clk_release_q,
	output reg         core_run_q,
	output reg         fail_mon_active_q,
	output reg         use_fast_rc_q,
	output reg         clk_fail_trap_q,
	output reg         wreg_reset_q,
	output reg         irq_q
);
	localparam ST_POR    = 3'h0;
	localparam ST_PUD    = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_RUN    = 3'h3;
	localparam ST_IDLE   = 3'h4;

	reg  [2:0]      state_q;
	reg  [31:0]     cnt_q;
	reg  [7:0]      ctrl_q;
	reg  [15:0]     cause_q;
	reg  [15:0]     osc_q;
	reg  [2:0]      irq_stat_q;
	reg  [2:0]      irq_mask_q;
	reg  [10:0]     ost_q;
	reg             ost_done_q;
	reg             run_seen_q;
	reg             wr_event_q;
	wire [NREG-1:0] wvalid;
	wire            bad_use;
	wire [1:0]      src;
	wire            pll_en;
	wire            need_settle;
	wire            osc_ready;
	reg  [31:0]     pud_cyc;

	assign src    = ctrl_q[`RSS_CTRL_SRC_HI:`RSS_CTRL_SRC_LO];
	assign pll_en = ctrl_q[`RSS_CTRL_PLL_EN];
	// settle delay only for crystal or PLL derived clocks
	assign need_settle = (src == `RSS_SRC_CRYSTAL) || pll_en;
	// start-up timer only applies to a crystal; lock is only awaited with the PLL enabled
	assign osc_ready = ((src != `RSS_SRC_CRYSTAL) || ost_done_q) && (!pll_en || pll_lock);

	always @* begin
		case (ctrl_q[`RSS_CTRL_PUD_SEL_HI:`RSS_CTRL_PUD_SEL_LO])
			2'h1:    pud_cyc = PUD_4_CYC;
			2'h2:    pud_cyc = PUD_16_CYC;
			2'h3:    pud_cyc = PUD_64_CYC;
			default: pud_cyc = 32'h0;
		endcase
	end

	// oscillator start-up timer, counted on oscillator ticks, free of the reset delays
	always @(posedge clk_sys) begin
		if (sys_rst || por_pulse || bor_pulse) begin
			ost_q      <= 11'h0;
			ost_done_q <= 1'b0;
		end else if (osc_tick && !ost_done_q) begin
			ost_q      <= ost_q + 11'h1;
			ost_done_q <= (ost_q == `RSS_OST_PERIODS - 1);
		end
	end

	// delay sequencer, counted on the always-running reference clock
	always @(posedge clk_sys) begin
		if (sys_rst || por_pulse) begin
			state_q        <= ST_POR;
			cnt_q          <= 32'h0;
			master_reset_q <= 1'b1;
		end else if (bor_pulse) begin
			state_q        <= ST_PUD;
			cnt_q          <= 32'h0;
			master_reset_q <= 1'b1;
		end else begin
			case (state_q)
				ST_POR: begin
					if (cnt_q >= `RSS_POWER_ON_CYC - 1) begin
						state_q <= ST_PUD;
						cnt_q   <= 32'h0;
					end else
						cnt_q <= cnt_q + 32'h1;
				end
				ST_PUD: begin
					if (cnt_q >= pud_cyc) begin
						master_reset_q <= 1'b0;
						state_q        <= need_settle ? ST_SETTLE : ST_RUN;
						cnt_q          <= 32'h0;
					end else
						cnt_q <= cnt_q + 32'h1;
				end
				ST_SETTLE: begin
					if (cnt_q >= `RSS_SETTLE_CYC - 1) begin
						state_q <= ST_RUN;
						cnt_q   <= 32'h0;
					end else
						cnt_q <= cnt_q + 32'h1;
				end
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_POR;
			endcase
		end
	end

	// clock release, core run and fail monitor
	always @(posedge clk_sys) begin
		if (sys_rst || master_reset_q) begin
			clk_release_q     <= 1'b0;
			core_run_q        <= 1'b0;
			fail_mon_active_q <= 1'b0;
			clk_fail_trap_q   <= 1'b0;
			use_fast_rc_q     <= 1'b0;
		end else begin
			clk_release_q     <= osc_ready || use_fast_rc_q;
			core_run_q        <= clk_release_q;
			fail_mon_active_q <= ctrl_q[`RSS_CTRL_FAIL_MON_EN] && (state_q == ST_RUN);
			clk_fail_trap_q   <= 1'b0;
			// a clock not yet ready at arming counts as failed
			if (fail_mon_active_q && !use_fast_rc_q && (!osc_ready || !clk_alive)) begin
				use_fast_rc_q   <= 1'b1;
				clk_fail_trap_q <= 1'b1;
			end
		end
	end

	rss_wreg_track #(
		.NREG      (NREG)
	) u_wreg (
		.clk_sys   (clk_sys),
		.clr       (sys_rst || master_reset_q),
		.load_stb  (reg_wr && reg_addr == `RSS_ADDR_WREG_LOAD),
		.load_word (reg_wdata[4]),
		.load_idx  (reg_wdata[3:0]),
		.use_stb   (reg_wr && reg_addr == `RSS_ADDR_WREG_USE),
		.use_idx   (reg_wdata[3:0]),
		.valid_q   (wvalid),
		.bad_use_q (bad_use)
	);

	always @(posedge clk_sys) begin
		if (sys_rst)
			wreg_reset_q <= 1'b0;
		else
			wreg_reset_q <= bad_use;
	end

	// software registers; cause and control vary with reset type, control kept over brown-out
	always @(posedge clk_sys) begin
		if (sys_rst || por_pulse) begin
			cause_q <= `RSS_CAUSE_POR_VALUE;
			ctrl_q  <= `RSS_CTRL_RESET;
		end else begin
			if (reg_wr && reg_addr == `RSS_ADDR_CTRL)
				ctrl_q <= reg_wdata[7:0];
			if (reg_wr && reg_addr == `RSS_ADDR_CAUSE)
				cause_q <= reg_wdata;
			if (bor_pulse)
				cause_q[`RSS_CAUSE_BROWNOUT] <= 1'b1;
			if (trap_conflict)
				cause_q[`RSS_CAUSE_TRAP] <= 1'b1;
			if (bad_use)
				cause_q[`RSS_CAUSE_BAD_OP] <= 1'b1;
		end
	end

	// osc control: reset value follows configured source and PLL enable, same for every reset type
	always @(posedge clk_sys) begin
		if (sys_rst || por_pulse || bor_pulse) begin
			osc_q <= {11'h0, 2'h0, ctrl_q[`RSS_CTRL_SRC_HI:`RSS_CTRL_SRC_LO], pll_en};
		end else begin
			osc_q[`RSS_OSC_LOCK]   <= pll_en && pll_lock;
			osc_q[`RSS_OSC_USE_RC] <= use_fast_rc_q;
		end
	end

	// interrupt status: set wins over write-one-to-clear
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
			run_seen_q <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			run_seen_q <= core_run_q;
			if (reg_wr && reg_addr == `RSS_ADDR_IRQ_MASK)
				irq_mask_q <= reg_wdata[2:0];
			irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `RSS_ADDR_IRQ_STAT) ? reg_wdata[2:0] : 3'h0))
				| {bad_use, core_run_q && !run_seen_q, clk_fail_trap_q};
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// read port, data one cycle after the strobe
	always @(posedge clk_sys) begin
		if (sys_rst)
			reg_rdata <= 16'h0;
		else if (reg_rd) begin
			case (reg_addr)
				`RSS_ADDR_CTRL:     reg_rdata <= {8'h0, ctrl_q};
				`RSS_ADDR_STATUS:   reg_rdata <= {9'h0, state_q, core_run_q, clk_release_q, fail_mon_active_q,
					master_reset_q};
				`RSS_ADDR_CAUSE:    reg_rdata <= cause_q;
				`RSS_ADDR_OSCCTL:   reg_rdata <= osc_q;
				`RSS_ADDR_IRQ_STAT: reg_rdata <= {13'h0, irq_stat_q};
				`RSS_ADDR_IRQ_MASK: reg_rdata <= {13'h0, irq_mask_q};
				`RSS_ADDR_WREG_VAL: reg_rdata <= {{(16-NREG){1'b0}}, wvalid};
				default:            reg_rdata <= 16'h0;
			endcase
		end else
			reg_rdata <= 16'h0;
	end
endmodule

// ### rss_map.vh
// register offsets, field positions, reset values and timing constants of the start-up sequencer
`ifndef RSS_MAP_VH
`define RSS_MAP_VH

// register word addresses
`define RSS_ADDR_CTRL      4'h0
`define RSS_ADDR_STATUS    4'h1
`define RSS_ADDR_CAUSE     4'h2
`define RSS_ADDR_OSCCTL    4'h3
`define RSS_ADDR_IRQ_STAT  4'h4
`define RSS_ADDR_IRQ_MASK  4'h5
`define RSS_ADDR_WREG_LOAD 4'h6
`define RSS_ADDR_WREG_USE  4'h7
`define RSS_ADDR_WREG_VAL  4'h8

// control register fields
`define RSS_CTRL_FAIL_MON_EN 0
`define RSS_CTRL_PUD_SEL_LO  1
`define RSS_CTRL_PUD_SEL_HI  2
`define RSS_CTRL_SRC_LO      3
`define RSS_CTRL_SRC_HI      4
`define RSS_CTRL_PLL_EN      5
`define RSS_CTRL_RESET       8'h00

// clock source codes
`define RSS_SRC_RC       2'h0
`define RSS_SRC_EXTCLK   2'h1
`define RSS_SRC_CRYSTAL  2'h2

// reset-cause register fields and reset values
`define RSS_CAUSE_TRAP      15
`define RSS_CAUSE_BAD_OP    14
`define RSS_CAUSE_BROWNOUT  1
`define RSS_CAUSE_POWER_ON  0
`define RSS_CAUSE_POR_VALUE 16'h0003

// osc control register fields
`define RSS_OSC_LOCK     5
`define RSS_OSC_USE_RC   3

// interrupt status bits
`define RSS_IRQ_CLK_FAIL  0
`define RSS_IRQ_RUN       1
`define RSS_IRQ_BAD_PTR   2

// timing, reference clock at 25 MHz
`define RSS_CLK_MHZ            25
`define RSS_POWER_ON_DELAY_US  10
`define RSS_SETTLE_DELAY_US    100
`define RSS_PUD_4_MS           4
`define RSS_PUD_16_MS          16
`define RSS_PUD_64_MS          64
`define RSS_POWER_ON_CYC       (`RSS_POWER_ON_DELAY_US * `RSS_CLK_MHZ)
`define RSS_SETTLE_CYC         (`RSS_SETTLE_DELAY_US * `RSS_CLK_MHZ)
`define RSS_PUD_4_CYC          (`RSS_PUD_4_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_PUD_16_CYC         (`RSS_PUD_16_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_PUD_64_CYC         (`RSS_PUD_64_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_OST_PERIODS        1024

`endif

// ### rss_wreg_track.v
// per-register word-load validity tracking for the working register array
`timescale 1ns/10ps
module rss_wreg_track #(
	parameter NREG = 15
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             clr,
	// load and use events
	input  wire             load_stb,
	input  wire             load_word,
	input  wire [3:0]       load_idx,
	input  wire             use_stb,
	input  wire [3:0]       use_idx,
	// results
	output reg  [NREG-1:0]  valid_q,
	output reg              bad_use_q
);
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			always @(posedge clk_sys) begin
				if (clr)
					valid_q[g] <= 1'b0;
				else if (load_stb && load_idx == g)
					valid_q[g] <= load_word; // byte loads never validate
			end
		end
	endgenerate

	always @(posedge clk_sys) begin
		if (clr)
			bad_use_q <= 1'b0;
		else
			bad_use_q <= use_stb && (use_idx < NREG) && !valid_q[use_idx];
	end
endmodule

// ### rss_seq_monitor.sv
// port-level assertion checker for the start-up sequencer
`timescale 1ns/10ps
module rss_seq_chk (
	// clock and reset
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        por_pulse,
	// register port
	input wire [3:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	// sequencer outputs
	input wire        master_reset_q,
	input wire        clk_release_q,
	input wire        core_run_q,
	input wire        fail_mon_active_q,
	input wire        use_fast_rc_q,
	input wire        clk_fail_trap_q,
	input wire        wreg_reset_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	reg [15:0] por_cnt_q;
	// saturates so a long run never wraps back under the power-on figure
	always @(posedge clk_sys) begin
		if (sys_rst || por_pulse)
			por_cnt_q <= 16'h0000;
		else if (por_cnt_q != 16'hffff)
			por_cnt_q <= por_cnt_q + 16'h0001;
	end
	a_run_after_release: assert property ($rose(core_run_q) |-> $past(clk_release_q))
		else $error("core started before clock release");
	a_run_out_reset: assert property ($rose(core_run_q) |-> !master_reset_q)
		else $error("core started in master reset");
	a_por_delay_min: assert property ($fell(master_reset_q) |-> por_cnt_q >= 16'd250)
		else $error("master reset released too early");
	a_mon_after_reset: assert property ($rose(fail_mon_active_q) |-> !master_reset_q)
		else $error("monitor armed in master reset");
	a_trap_to_rc: assert property (clk_fail_trap_q |-> ##[0:1] use_fast_rc_q)
		else $error("no switch to fast rc");
	a_trap_one_cycle: assert property (clk_fail_trap_q |=> !clk_fail_trap_q)
		else $error("trap longer than a cycle");
	a_trap_when_armed: assert property (clk_fail_trap_q |-> fail_mon_active_q || $past(fail_mon_active_q))
		else $error("trap without armed monitor");
	a_bad_ptr_cause: assert property (wreg_reset_q |-> $past(reg_wr && reg_addr == 4'h7, 2))
		else $error("pointer reset without use");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
endmodule

bind rss_seq rss_seq_chk u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .por_pulse(por_pulse),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.master_reset_q(master_reset_q), .clk_release_q(clk_release_q), .core_run_q(core_run_q),
	.fail_mon_active_q(fail_mon_active_q), .use_fast_rc_q(use_fast_rc_q),
	.clk_fail_trap_q(clk_fail_trap_q), .wreg_reset_q(wreg_reset_q)
);

// ### rss_osc_model.sv
// oscillator and pll stand-in: 0 dead, 1 crystal running, 2 external clock with pll
`timescale 1ns/10ps
module rss_osc_model (
	// clock and scenario
	input  wire       clk_sys,
	input  wire [1:0] mode,
	// oscillator side
	output reg        osc_tick = 1'b0,
	output reg        pll_lock = 1'b0,
	output reg        clk_alive = 1'b0
);
	// start-up runs on its own timeline, unaware of the reset delays
	always @(posedge clk_sys) begin
		osc_tick  <= mode == 2'h1 && !osc_tick; // one period every two cycles
		pll_lock  <= mode != 2'h0;
		clk_alive <= mode != 2'h0;
	end
endmodule

// ### rss_seq_tb.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/10ps
module rss_seq_tb;
	reg         clk_sys, sys_rst, por_pulse, bor_pulse, trap_conflict, reg_wr, reg_rd;
	reg  [3:0]  reg_addr;
	reg  [15:0] reg_wdata, d;
	reg  [1:0]  mode;
	wire        osc_tick, pll_lock, clk_alive, master_reset_q, clk_release_q, core_run_q;
	wire        fail_mon_active_q, use_fast_rc_q, clk_fail_trap_q, wreg_reset_q, irq_q;
	wire [15:0] reg_rdata;
	integer     n_mismatch, n_checks, n, s, d0;
	rss_seq #(.PUD_4_CYC(32'd20), .PUD_16_CYC(32'd40), .PUD_64_CYC(32'd80)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .por_pulse(por_pulse), .bor_pulse(bor_pulse),
		.trap_conflict(trap_conflict), .osc_tick(osc_tick), .pll_lock(pll_lock), .clk_alive(clk_alive),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.master_reset_q(master_reset_q), .clk_release_q(clk_release_q), .core_run_q(core_run_q),
		.fail_mon_active_q(fail_mon_active_q), .use_fast_rc_q(use_fast_rc_q),
		.clk_fail_trap_q(clk_fail_trap_q), .wreg_reset_q(wreg_reset_q), .irq_q(irq_q));
	rss_osc_model osc (.clk_sys(clk_sys), .mode(mode), .osc_tick(osc_tick), .pll_lock(pll_lock),
		.clk_alive(clk_alive));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] v);
		begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	// data registered at the taking edge is seen before the next edge updates land
	task rd(input [3:0] a);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			@(posedge clk_sys);
			d = reg_rdata;
		end
	endtask
	task pulse(input [2:0] v);
		begin
			{por_pulse, bor_pulse, trap_conflict} <= v;
			@(posedge clk_sys);
			{por_pulse, bor_pulse, trap_conflict} <= 3'h0;
			@(posedge clk_sys);
		end
	endtask
	function sig(input integer k);
		case (k)
			0: sig = core_run_q;
			1: sig = clk_fail_trap_q;
			2: sig = !master_reset_q;
			3: sig = fail_mon_active_q;
			4: sig = master_reset_q;
			default: sig = wreg_reset_q;
		endcase
	endfunction
	task wait_hi(input integer k, input integer lim);
		begin
			n = 0;
			while (sig(k) !== 1'b1 && n < lim) begin
				@(posedge clk_sys);
				n = n + 1;
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_mismatch);
			if (n_mismatch == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#800000;
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		{sys_rst, por_pulse, bor_pulse, trap_conflict, reg_wr, reg_rd} = 6'h20;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		mode = 2'h0;
		n_mismatch = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		pulse(3'h4);
		rd(4'h2); chk(d, 16'h0003);
		pulse(3'h1);
		rd(4'h2); chk(d, 16'h8003);
		wr(4'h2, 16'h0000);
		rd(4'h2); chk(d, 16'h0000);
		rd(4'hf); chk(d, 16'h0000);
		rd(4'h0); chk(d, 16'h0000);
		$display("done: reset values");
		mode <= 2'h1;
		wr(4'h0, 16'h0013);
		wait_hi(2, 1000);
		wait_hi(3, 3000); chk(n >= 2500 && n <= 2503, 1);
		chk(core_run_q, 1);
		chk(use_fast_rc_q, 0);
		rd(4'h4); chk(d, 16'h0002);
		$display("done: crystal start");
		for (s = 0; s < 4; s = s + 1) begin
			wr(4'h0, s * 2 + 1);
			pulse(3'h2);
			wait_hi(4, 100);
			wait_hi(2, 200);
			if (s == 0)
				d0 = n;
			chk(n - d0, s == 0 ? 0 : 20 << (s - 1));
			wait_hi(3, 10); chk(n < 4, 1);
		end
		$display("done: power-up select");
		mode <= 2'h0;
		wr(4'h4, 16'h0007);
		wr(4'h5, 16'h0001);
		wr(4'h0, 16'h0011);
		pulse(3'h2);
		wait_hi(1, 3000); chk(n < 3000, 1);
		repeat (2) @(posedge clk_sys);
		chk(use_fast_rc_q, 1);
		chk(irq_q, 1);
		wr(4'h5, 16'h0000);
		@(posedge clk_sys); chk(irq_q, 0);
		rd(4'h4); chk(d & 16'h0001, 16'h0001);
		wr(4'h4, 16'h0007);
		wr(4'h5, 16'h0001);
		@(posedge clk_sys); chk(irq_q, 0);
		$display("done: clock fail trap");
		mode <= 2'h2;
		wr(4'h0, 16'h0029);
		pulse(3'h2);
		wait_hi(4, 100);
		wait_hi(2, 200);
		wait_hi(3, 3000); chk(n >= 2500, 1);
		repeat (2) @(posedge clk_sys);
		chk(core_run_q, 1);
		chk(use_fast_rc_q, 0);
		rd(4'h4); chk(d & 16'h0001, 16'h0000);
		rd(4'h3); chk(d, 16'h0023);
		rd(4'h1); chk(d, 16'h003e);
		$display("done: external clock with pll");
		wr(4'h6, 16'h0003);
		wr(4'h6, 16'h0003);
		rd(4'h8); chk(d & 16'h0008, 16'h0000);
		wr(4'h7, 16'h0003);
		wait_hi(5, 4); chk(n < 4, 1);
		rd(4'h2); chk(d & 16'h4000, 16'h4000);
		rd(4'h4); chk(d & 16'h0004, 16'h0004);
		wr(4'h6, 16'h0015);
		rd(4'h8); chk(d & 16'h0020, 16'h0020);
		wr(4'h7, 16'h0005);
		wait_hi(5, 4); chk(n, 4);
		$display("done: working registers");
		stop_test;
	end
endmodule
